//--- ecss_consts.vh
// timing constants and field layouts for the expansion card strobe sequencer
`ifndef ECSS_CONSTS_VH
`define ECSS_CONSTS_VH
`define ECSS_LEAD_MIN      7'h02
`define ECSS_LEAD_MAX      7'h7F
`define ECSS_TRAIL_MAX     6'h3F
`define ECSS_WDATA_LEAD    8'h01
`define ECSS_WDATA_TRAIL   3'h4
`define ECSS_CMD_MIN       8'h01
`define ECSS_ACC_MEM_WR    2'h0
`define ECSS_ACC_MEM_RD    2'h1
`define ECSS_ACC_IO_WR     2'h2
`define ECSS_ACC_IO_RD     2'h3
`define ECSS_CODE_W        3
`define ECSS_ADDR_W        26
`endif

//--- ecss_pin_sync.v
// three-stage synchroniser for a card pin, change accepted when stages two and three agree
`timescale 1ns/1ps
module ecss_pin_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire clock_i,
  input  wire srst_i,
  input  wire pin_i,
  output reg  level_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // stage one is read only by stage two
  always @(posedge clock_i) begin
    if (srst_i) begin
      s1_r    <= RST_VAL;
      s2_r    <= RST_VAL;
      s3_r    <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule

//--- ecss_sequencer.v
// expansion card strobe sequencer: address, strobe and data phases of one card access
`timescale 1ns/1ps
`include "ecss_consts.vh"
module ecss_sequencer #(
  parameter AW = `ECSS_ADDR_W
) (
  input  wire          clock_i,
  input  wire          srst_i,
  input  wire          req_i,
  input  wire [1:0]    acc_kind_i,
  input  wire          acc_wide_i,
  input  wire [AW-1:0] acc_addr_i,
  input  wire          acc_attr_i,
  input  wire          acc_socket_i,
  input  wire [15:0]   acc_wdata_i,
  input  wire [6:0]    cmd_lead_field_i,
  input  wire [5:0]    cmd_trail_field_i,
  input  wire [2:0]    strobe_wait_code_i,
  input  wire          card_wait_n_i,
  input  wire          io_width_indicator_n_i,
  input  wire [15:0]   card_data_i,
  output reg           busy_o,
  output reg           done_o,
  output reg  [15:0]   rdata_o,
  output reg  [AW-1:0] card_address_bus_o,
  output reg           attribute_space_select_n_o,
  output reg           socket_select_n_o,
  output reg           card_write_strobe_n_o,
  output reg           card_output_enable_strobe_n_o,
  output reg           card_io_write_strobe_n_o,
  output reg           card_io_read_strobe_n_o,
  output reg  [15:0]   card_data_o,
  output reg           card_data_oe_n_o
);
  // access phases, one pass per strobe cycle
  localparam ST_IDLE  = 3'h0;
  localparam ST_LEAD  = 3'h1;
  localparam ST_WSMP  = 3'h2;
  localparam ST_WAIT  = 3'h3;
  localparam ST_TAIL  = 3'h4;
  localparam ST_TRAIL = 3'h5;

  // wait-sample delay from the strobe wait code, never below one cycle
  function [7:0] wait_delay;
    input [2:0] code;
    begin
      wait_delay = {5'h00, code} + 8'h01;
    end
  endfunction

  // post-wait tail from the strobe wait code, never below one cycle
  function [7:0] tail_delay;
    input [2:0] code;
    begin
      tail_delay = {6'h00, code[2:1]} + 8'h01;
    end
  endfunction

  // setup field below the legal floor is raised to the floor
  function [6:0] lead_clamp;
    input [6:0] field;
    begin
      if (field < `ECSS_LEAD_MIN) begin
        lead_clamp = `ECSS_LEAD_MIN;
      end else begin
        lead_clamp = field;
      end
    end
  endfunction

  // synchronised card levels, both idle high
  wire wait_lvl;
  wire wide_lvl;

  // card pins come from outside our clock
  ecss_pin_sync #(.RST_VAL(1'b1)) u_wait_sync (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .pin_i   (card_wait_n_i),
    .level_o (wait_lvl)
  );

  ecss_pin_sync #(.RST_VAL(1'b1)) u_wide_sync (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .pin_i   (io_width_indicator_n_i),
    .level_o (wide_lvl)
  );

  reg [2:0]  state_r;
  reg [7:0]  cnt_r;
  reg [6:0]  lead_r;
  reg [5:0]  trail_r;
  reg [2:0]  code_r;
  reg [1:0]  kind_r;
  reg        split_r;
  reg        second_r;
  reg [2:0]  wd_hold_r;
  reg [15:0] wdata_r;
  reg [7:0]  wide_cnt_r;

  wire is_write = (kind_r == `ECSS_ACC_MEM_WR) || (kind_r == `ECSS_ACC_IO_WR);
  wire is_io    = kind_r[1];

  // card counts as 16-bit once its indicator has stood low long enough
  wire          card_is_wide = (wide_cnt_r >= 8'h03);
  // write data goes out one cycle ahead of the strobe edge
  wire          wdata_due    = is_write && (cnt_r + `ECSS_WDATA_LEAD == {1'b0, lead_r});
  // byte lane bit set for the second half of a split access
  wire [AW-1:0] odd_byte     = {{(AW-1){1'b0}}, 1'b1};

  // count cycles that the width indicator has been low, saturating
  always @(posedge clock_i) begin
    if (srst_i) begin
      wide_cnt_r <= 8'h00;
    end else if (wide_lvl) begin
      wide_cnt_r <= 8'h00;
    end else if (wide_cnt_r != 8'hFF) begin
      wide_cnt_r <= wide_cnt_r + 8'h01;
    end
  end

  // strobe select: one of four, all driven by the same timing
  task drive_strobe;
    input low;
    begin
      card_write_strobe_n_o         <= ~(low && kind_r == `ECSS_ACC_MEM_WR);
      card_output_enable_strobe_n_o <= ~(low && kind_r == `ECSS_ACC_MEM_RD);
      card_io_write_strobe_n_o      <= ~(low && kind_r == `ECSS_ACC_IO_WR);
      card_io_read_strobe_n_o       <= ~(low && kind_r == `ECSS_ACC_IO_RD);
    end
  endtask

  // main access sequencer
  always @(posedge clock_i) begin
    if (srst_i) begin
      // strobes, selects and data driver all rest high
      state_r                       <= ST_IDLE;
      cnt_r                         <= 8'h00;
      lead_r                        <= `ECSS_LEAD_MIN;
      trail_r                       <= 6'h00;
      code_r                        <= 3'h0;
      kind_r                        <= 2'h0;
      split_r                       <= 1'b0;
      second_r                      <= 1'b0;
      wd_hold_r                     <= 3'h0;
      wdata_r                       <= 16'h0000;
      busy_o                        <= 1'b0;
      done_o                        <= 1'b0;
      rdata_o                       <= 16'h0000;
      card_address_bus_o            <= {AW{1'b0}};
      attribute_space_select_n_o    <= 1'b1;
      socket_select_n_o             <= 1'b1;
      card_write_strobe_n_o         <= 1'b1;
      card_output_enable_strobe_n_o <= 1'b1;
      card_io_write_strobe_n_o      <= 1'b1;
      card_io_read_strobe_n_o       <= 1'b1;
      card_data_o                   <= 16'h0000;
      card_data_oe_n_o              <= 1'b1;
    end else begin
      done_o <= 1'b0;
      // write data trails the strobe by a fixed count, then released
      if (wd_hold_r != 3'h0) begin
        wd_hold_r <= wd_hold_r - 3'h1;
        if (wd_hold_r == 3'h1) begin
          card_data_oe_n_o <= 1'b1;
        end
      end
      case (state_r)
        ST_IDLE: begin
          // a request made while busy never reaches this branch
          if (req_i) begin
            // fields sampled once, at access start
            lead_r   <= lead_clamp(cmd_lead_field_i);
            trail_r  <= cmd_trail_field_i;
            code_r   <= strobe_wait_code_i;
            kind_r   <= acc_kind_i;
            second_r <= 1'b0;
            wdata_r  <= acc_wdata_i;
            busy_o   <= 1'b1;
            // whole address group driven together
            card_address_bus_o         <= acc_addr_i;
            attribute_space_select_n_o <= ~acc_attr_i;
            socket_select_n_o          <= ~acc_socket_i;
            cnt_r    <= 8'h01;
            state_r  <= ST_LEAD;
            // a wide I/O request is remembered for the width decision
            split_r  <= acc_wide_i && acc_kind_i[1];
          end
        end

        // setup: address group stands, strobe still high
        ST_LEAD: begin
          // data leads so the card sees it settled at the falling edge
          if (wdata_due) begin
            card_data_o      <= (split_r && second_r) ? {8'h00, wdata_r[15:8]}
                                : wdata_r;
            card_data_oe_n_o <= 1'b0;
          end
          if (cnt_r == {1'b0, lead_r}) begin
            // width sampled here; indicator must have led by three cycles
            if (split_r && !second_r && is_io && card_is_wide) begin
              split_r <= 1'b0;
            end
            drive_strobe(1'b1);
            cnt_r   <= 8'h01;
            state_r <= ST_WSMP;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end

        // strobe low; card wait not trusted until it has had time to settle
        ST_WSMP: begin
          // no look at card wait until the code's delay passes
          if (cnt_r >= wait_delay(code_r)) begin
            state_r <= ST_WAIT;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end

        // wait sampling: no upper bound, the card decides the length
        ST_WAIT: begin
          // stretch one cycle at a time while card asks to wait
          if (wait_lvl) begin
            cnt_r   <= 8'h01;
            state_r <= ST_TAIL;
          end else begin
            state_r <= ST_WAIT;
          end
        end

        // tail: a wait reasserted here is ignored, the strobe rises anyway
        ST_TAIL: begin
          if (cnt_r >= tail_delay(code_r)) begin
            // read data captured as strobe rises
            if (!is_write) begin
              if (split_r && second_r) begin
                rdata_o[15:8] <= card_data_i[7:0];
              end else begin
                rdata_o <= card_data_i;
              end
            end
            drive_strobe(1'b0);
            if (is_write) begin
              wd_hold_r <= `ECSS_WDATA_TRAIL;
            end
            cnt_r   <= 8'h00;
            state_r <= ST_TRAIL;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end

        // hold: strobe high, address group and write data still driven
        ST_TRAIL: begin
          // address and write data stay put through hold and data trail
          if (cnt_r >= {2'h0, trail_r} && (!is_write || wd_hold_r <= 3'h1)) begin
            if (split_r && !second_r) begin
              // second byte cycle at the odd address
              second_r           <= 1'b1;
              card_address_bus_o <= card_address_bus_o | odd_byte;
              cnt_r              <= 8'h01;
              state_r            <= ST_LEAD;
            end else begin
              busy_o  <= 1'b0;
              done_o  <= 1'b1;
              attribute_space_select_n_o <= 1'b1;
              socket_select_n_o          <= 1'b1;
              state_r <= ST_IDLE;
            end
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end

        // unused state codes fall back to idle
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

//--- ecss_sequencer_properties.sv
// concurrent checks on the strobe sequencer ports
`timescale 1ns/1ps
module ecss_sequencer_properties (
  input wire logic          clock_i,
  input wire logic          srst_i,
  input wire logic          card_wait_n_i,
  input wire logic          busy_o,
  input wire logic [25:0]   card_address_bus_o,
  input wire logic          attribute_space_select_n_o,
  input wire logic          socket_select_n_o,
  input wire logic          card_write_strobe_n_o,
  input wire logic          card_output_enable_strobe_n_o,
  input wire logic          card_io_write_strobe_n_o,
  input wire logic          card_io_read_strobe_n_o,
  input wire logic [15:0]   card_data_o,
  input wire logic          card_data_oe_n_o
);
  // all four strobes folded: low while any command is active
  wire [3:0] stb_n = {card_io_read_strobe_n_o, card_io_write_strobe_n_o,
                      card_output_enable_strobe_n_o, card_write_strobe_n_o};
  wire       cmd_n = &stb_n;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  property p_setup;
    $fell(cmd_n) |-> $stable(card_address_bus_o)
      && card_address_bus_o == $past(card_address_bus_o, 2);
  endproperty
  a_setup: assert property (p_setup) else $error("address moved before strobe");
  property p_group;
    $fell(cmd_n) |-> $stable(attribute_space_select_n_o) && $stable(socket_select_n_o);
  endproperty
  a_group: assert property (p_group) else $error("selects moved at strobe");
  property p_hold;
    $rose(cmd_n) |-> $stable(card_address_bus_o) && $stable(socket_select_n_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address lost at strobe rise");
  property p_wlead;
    $fell(card_write_strobe_n_o) |-> !$past(card_data_oe_n_o) && $stable(card_data_o);
  endproperty
  a_wlead: assert property (p_wlead) else $error("write data late");
  property p_wtrail;
    $rose(card_write_strobe_n_o) |-> (!card_data_oe_n_o && $stable(card_data_o)) [*4];
  endproperty
  a_wtrail: assert property (p_wtrail) else $error("write data dropped early");
  property p_minlow;
    $fell(cmd_n) |-> !cmd_n [*2];
  endproperty
  a_minlow: assert property (p_minlow) else $error("strobe too short");
  property p_waitext;
    (!cmd_n && !card_wait_n_i) [*8] ##1 (!cmd_n && !card_wait_n_i) |=> !cmd_n;
  endproperty
  a_waitext: assert property (p_waitext) else $error("strobe rose during wait");
  property p_tail;
    !cmd_n && $rose(card_wait_n_i) |=> !cmd_n [*3];
  endproperty
  a_tail: assert property (p_tail) else $error("strobe rose without tail");
  property p_onestb;
    $onehot0(~stb_n) && (busy_o || cmd_n);
  endproperty
  a_onestb: assert property (p_onestb) else $error("bad strobe set");
  c_wr: cover property ($fell(card_write_strobe_n_o));
  c_ior: cover property ($fell(card_io_read_strobe_n_o));
  c_wait: cover property (!cmd_n && $rose(card_wait_n_i));
endmodule
bind ecss_sequencer ecss_sequencer_properties u_props (.clock_i(clock_i), .srst_i(srst_i),
  .card_wait_n_i(card_wait_n_i), .busy_o(busy_o), .card_address_bus_o(card_address_bus_o),
  .attribute_space_select_n_o(attribute_space_select_n_o),
  .socket_select_n_o(socket_select_n_o), .card_write_strobe_n_o(card_write_strobe_n_o),
  .card_output_enable_strobe_n_o(card_output_enable_strobe_n_o),
  .card_io_write_strobe_n_o(card_io_write_strobe_n_o),
  .card_io_read_strobe_n_o(card_io_read_strobe_n_o), .card_data_o(card_data_o),
  .card_data_oe_n_o(card_data_oe_n_o));

//--- ecss_card_model.sv
// behavioural expansion card: wait, width indicator and read data
`timescale 1ns/1ps
module ecss_card_model (
  input  wire logic        clock_i,
  input  wire logic        cmd_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        addr0_i,
  input  wire logic [7:0]  wait_len_i,
  input  wire logic        wide_i,
  input  wire logic [15:0] rdata_i,
  output wire logic        card_wait_n_o,
  output wire logic        io_width_indicator_n_o,
  output wire logic [15:0] card_data_o
);
  reg [7:0]  cnt_r = 8'h00;
  reg        cmd_q_r = 1'b1;
  reg [15:0] last_r = 16'h0000;
  // wait held low a set count after each strobe fall
  always @(posedge clock_i) begin
    cmd_q_r <= cmd_n_i;
    if (cmd_q_r && !cmd_n_i)
      cnt_r <= wait_len_i;
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
    if (!rd_n_i)
      last_r <= card_data_o;
  end
  assign card_wait_n_o = (cnt_r == 8'h00);
  // width held steady, so lead and trail margins always met
  assign io_width_indicator_n_o = ~wide_i;
  // data valid for the whole strobe; released bus shows inverse
  wire [15:0] drv = wide_i ? rdata_i : {~rdata_i[15:8], addr0_i ? rdata_i[15:8] : rdata_i[7:0]};
  assign card_data_o = rd_n_i ? ~last_r : drv;
endmodule

//--- ecss_sequencer_test.sv
// self-checking bench for the strobe sequencer
`timescale 1ns/1ps
module ecss_sequencer_test;
  reg          clock_i = 1'b0, srst_i = 1'b1, req_i = 1'b0, acc_wide_i = 1'b0;
  reg          acc_attr_i = 1'b0, acc_socket_i = 1'b0, wide_card = 1'b1;
  reg  [1:0]   acc_kind_i = 2'h0;
  reg  [25:0]  acc_addr_i = 26'h0000000;
  reg  [15:0]  acc_wdata_i = 16'h0000, card_rdata = 16'h0000;
  reg  [6:0]   lead_i = 7'h02;
  reg  [5:0]   trail_i = 6'h00;
  reg  [2:0]   code_i = 3'h0;
  reg  [7:0]   wait_len = 8'h00;
  wire         wait_n, width_n, busy_o, done_o, attr_n, sock_n, wr_n, oe_n, iow_n, ior_n, doe_n;
  wire [15:0]  card_data, rdata_o, card_data_o;
  wire [25:0]  addr_o;
  wire [3:0]   stb_n = {ior_n, iow_n, oe_n, wr_n};
  integer      err_total = 0, tests_run = 0, lead_cnt, hold_cnt, low_cnt = 0, low_max, i;
  integer      falls [0:3];
  reg  [25:0]  fall_addr;
  reg  [15:0]  fall_data;
  reg  [3:0]   stb_q = 4'hF;
  reg          fall_sel, seen = 1'b0, pre_oe, doe_q = 1'b1;
  ecss_sequencer u_dut (.clock_i(clock_i), .srst_i(srst_i), .req_i(req_i),
    .acc_kind_i(acc_kind_i), .acc_wide_i(acc_wide_i), .acc_addr_i(acc_addr_i),
    .acc_attr_i(acc_attr_i), .acc_socket_i(acc_socket_i), .acc_wdata_i(acc_wdata_i),
    .cmd_lead_field_i(lead_i), .cmd_trail_field_i(trail_i), .strobe_wait_code_i(code_i),
    .card_wait_n_i(wait_n), .io_width_indicator_n_i(width_n), .card_data_i(card_data),
    .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .card_address_bus_o(addr_o),
    .attribute_space_select_n_o(attr_n), .socket_select_n_o(sock_n),
    .card_write_strobe_n_o(wr_n), .card_output_enable_strobe_n_o(oe_n),
    .card_io_write_strobe_n_o(iow_n), .card_io_read_strobe_n_o(ior_n),
    .card_data_o(card_data_o), .card_data_oe_n_o(doe_n));
  ecss_card_model u_card (.clock_i(clock_i), .cmd_n_i(&stb_n), .rd_n_i(oe_n & ior_n),
    .addr0_i(addr_o[0]), .wait_len_i(wait_len), .wide_i(wide_card), .rdata_i(card_rdata),
    .card_wait_n_o(wait_n), .io_width_indicator_n_o(width_n), .card_data_o(card_data));
  initial forever #20 clock_i = ~clock_i;
  // strobe monitor: lead, hold and low-time counts, values at each fall
  always @(posedge clock_i) begin
    stb_q <= stb_n;
    doe_q <= doe_n;
    if (busy_o && &stb_n && !seen) lead_cnt = lead_cnt + 1;
    if (seen && &stb_n && !sock_n) hold_cnt = hold_cnt + 1;
    low_cnt = &stb_n ? 0 : low_cnt + 1;
    if (low_cnt > low_max) low_max = low_cnt;
    for (i = 0; i < 4; i = i + 1)
      if (stb_q[i] && !stb_n[i]) begin
        falls[i] = falls[i] + 1;
        seen = 1'b1;
        fall_addr = addr_o;
        fall_data = card_data_o;
        fall_sel = attr_n;
        pre_oe = ~doe_q;
      end
  end
  task end_of_test;
    begin
      if (err_total == 0 && tests_run > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task check(input string name, input [31:0] sv, input [31:0] ev);
    begin
      tests_run = tests_run + 1;
      if (sv !== ev) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %0h seen %0h", name, ev, sv);
      end
    end
  endtask
  // one access from request to done; a hang is cut off and reported
  task run(input [1:0] k, input w, input [25:0] a, input [15:0] d,
           input [6:0] l, input [5:0] t, input [2:0] c);
    integer n;
    begin
      {acc_kind_i, acc_wide_i, acc_addr_i, acc_wdata_i, lead_i, trail_i, code_i} = {k, w, a, d, l, t, c};
      {lead_cnt, hold_cnt, low_max, seen, n} = 0;
      for (i = 0; i < 4; i = i + 1) falls[i] = 0;
      req_i = 1'b1;
      @(posedge clock_i) #1 req_i = 1'b0;
      while (done_o !== 1'b1 && n < 3000) begin @(posedge clock_i) #1 n = n + 1; end
      if (n >= 3000) begin check("done_wait", 0, 1); end_of_test; end
      @(posedge clock_i) #1;
    end
  endtask
  task t_mem_write;
    begin
      acc_attr_i = 1'b1;
      run(2'h0, 1'b0, 26'h2ABCDEF, 16'hA5C3, 7'h02, 6'h00, 3'h0);
      check("wr_falls", falls[0], 1);
      check("wr_lead", lead_cnt, 2);
      check("wr_addr", fall_addr, 26'h2ABCDEF);
      check("wr_attr", fall_sel, 0);
      check("wr_data", fall_data, 16'hA5C3);
      check("wr_pre", pre_oe, 1);
    end
  endtask
  task t_mem_read;
    begin
      {acc_attr_i, acc_socket_i, wait_len, card_rdata} = {2'b01, 8'h14, 16'h5AA5};
      run(2'h1, 1'b0, 26'h3FFFFFF, 16'h0000, 7'h7F, 6'h3F, 3'h7);
      check("rd_falls", falls[1], 1);
      check("rd_data", rdata_o, 16'h5AA5);
      check("rd_lead", lead_cnt, 127);
      check("rd_hold", hold_cnt >= 63, 1);
      check("rd_wait", low_max >= 20, 1);
      wait_len = 8'h00;
    end
  endtask
  task t_io_wide;
    begin
      card_rdata = 16'hC33C;
      run(2'h3, 1'b1, 26'h0000040, 16'h0000, 7'h00, 6'h01, 3'h3);
      check("io_falls", falls[3], 1);
      check("io_lead", lead_cnt, 2);
      check("io_data", rdata_o, 16'hC33C);
    end
  endtask
  task t_io_split;
    begin
      {wide_card, card_rdata} = {1'b0, 16'h1234};
      // new 8-bit card: let its width level pass the synchroniser first
      repeat (8) @(posedge clock_i);
      #1;
      run(2'h2, 1'b1, 26'h0000100, 16'hBEEF, 7'h03, 6'h02, 3'h1);
      check("sw_falls", falls[2], 2);
      check("sw_addr", fall_addr, 26'h0000101);
      check("sw_data", fall_data[7:0], 8'hBE);
      run(2'h3, 1'b1, 26'h0000200, 16'h0000, 7'h03, 6'h02, 3'h1);
      check("sr_falls", falls[3], 2);
      check("sr_data", rdata_o, 16'h1234);
    end
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    #1 srst_i = 1'b0;
    t_mem_write;
    t_mem_read;
    t_io_wide;
    t_io_split;
    end_of_test;
  end
endmodule
